// >>> tb/dic_host_model.sv
// Host model: AHB-Lite master that services the interrupt units
`timescale 1ns/1ps

module dic_host_model
(
  input wire logic clk_sys,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Bus idle from time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // Bounded wait for hready; a stuck slave ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1)
    begin
      testbench.failures++;
      testbench.wrap_up();
    end
  endtask

  // One single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wr ? d : ~d; // Read cycles show no stale data
    wait_rdy();
    q = hrdata;
  endtask

  task automatic unfreeze(input logic [7:0] va);
    logic [31:0] q;
    xfer(1'b1, va, 32'hA5A5_A5A5, q);
  endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the dual interrupt controller
`timescale 1ns/1ps
`include "dic_params.svh"

module testbench;
  localparam logic [7:0] M0 = `DIC_OFF_MASK;
  localparam logic [7:0] P0 = `DIC_OFF_PEND;
  localparam logic [7:0] S0 = `DIC_OFF_STAT;
  localparam logic [7:0] V0 = `DIC_OFF_VECT;
  localparam logic [7:0] U1 = `DIC_UNIT_STRIDE;
  localparam logic [7:0] EV = `DIC_OFF_EVT;
  localparam logic [7:0] EM = `DIC_OFF_EVT_MASK;
  localparam logic [31:0] NV = 32'(`DIC_VEC_NONE);
  localparam logic [31:0] Z = 32'h0;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic standalone_mode = 1'b0;
  logic [27:0] fu_req_n = 28'hFFF_FFFF;
  logic [3:0] ext_request_pins = 4'hF;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic irq_out_n_unit0, irq_out_n_unit1, irq_out;
  int failures = 0;
  int checked = 0;
  // Outputs packed for one compare: hresp, irq_out, unit1, unit0
  wire [31:0] irqs = {28'h000_0000, hresp, irq_out, irq_out_n_unit1,
    irq_out_n_unit0};

  always #2 clk_sys = ~clk_sys;

  dic_top u_dic_top (.clk_sys, .rstn, .clk_en, .standalone_mode,
    .fu_req_n, .ext_request_pins, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .irq_out_n_unit0, .irq_out_n_unit1, .irq_out);

  dic_host_model u_dic_host_model (.clk_sys, .hready(hreadyout), .hrdata,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_dic_host_model.xfer(1'b0, a, Z, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_dic_host_model.xfer(1'b1, a, d, q);
  endtask
  // Output check off the edge, once updates have landed
  task automatic ck(input logic [31:0] e);
    #1;
    chk(irqs, e);
  endtask
  // Falling edge on the requests in v: {unit1, unit0}
  task automatic pulse(input logic [31:0] v);
    @(posedge clk_sys);
    fu_req_n <= ~v[27:0];
    ext_request_pins <= ~v[31:28];
    repeat (2) @(posedge clk_sys);
    fu_req_n <= 28'hFFF_FFFF;
    ext_request_pins <= 4'hF;
    repeat (8) @(posedge clk_sys); // Covers the pin synchroniser
  endtask
  task automatic wrap_up;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ck(32'h3);
    rd(M0, Z);
    rd(P0 + U1, Z);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, Z);
    wr(M0, 32'h0000_00FF);
    wr(M0 + U1, 32'h0000_FFFF);
    wr(EM, 32'h0000_0003);
    pulse(32'h0000_0208);
    ck(32'h2);
    rd(P0, Z);
    rd(S0, 32'h0000_0008);
    ck(32'h3);
    pulse(32'h0000_0028);
    pulse(32'h0000_0020);
    rd(P0, 32'h0000_0028);
    ck(32'h7);
    wr(EM, Z);
    ck(32'h3);
    wr(EM, 32'h0000_0003);
    pulse(32'h1000_0000);
    ck(32'h5);
    rd(V0 + U1, 32'h0000_000C);
    rd(S0 + U1, Z);
    rd(V0 + U1, NV);
    u_dic_host_model.unfreeze(V0 + U1);
    wr(EV, 32'h0000_0001);
    ck(32'h3);
    wr(S0, 32'h0000_0008);
    rd(S0, Z);
    rd(P0, 32'h0000_0028);
    u_dic_host_model.unfreeze(V0);
    repeat (2) @(posedge clk_sys);
    ck(32'h2);
    rd(V0, 32'h0000_0005);
    pulse(32'h0000_0040);
    rd(V0, 32'h0000_0003);
    rd(V0, NV);
    u_dic_host_model.unfreeze(V0);
    rd(V0, 32'h0000_0006);
    u_dic_host_model.unfreeze(V0);
    wr(P0, 32'h0000_0101);
    rd(P0, Z);
    rd(V0, Z);
    u_dic_host_model.unfreeze(V0);
    pulse(32'hFFFF_0000);
    rd(S0 + U1, 32'h0000_FFFF);
    rd(V0 + U1, 32'h0000_000F);
    wr(S0 + U1, 32'h0000_FFFF);
    rd(S0 + U1, Z);
    u_dic_host_model.unfreeze(V0 + U1);
    standalone_mode <= 1'b1;
    pulse(32'h0001_0001);
    ck(32'h3);
    @(posedge clk_sys);
    standalone_mode <= 1'b0;
    rd(S0, Z);
    // Enable low: request edges are missed and the bus stalls
    clk_en <= 1'b0;
    pulse(32'h0000_0001);
    chk({31'h0000_0000, hreadyout}, Z);
    ck(32'h3);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(P0, Z);
    wrap_up();
  end
endmodule

// >>> verilog/dic_params.svh
// Register offsets, reset values and codes of the interrupt controller
`ifndef DIC_PARAMS_SVH
`define DIC_PARAMS_SVH
`define DIC_OFF_MASK 8'h00
`define DIC_OFF_PEND 8'h04
`define DIC_OFF_STAT 8'h08
`define DIC_OFF_VECT 8'h0C
`define DIC_UNIT_STRIDE 8'h10
`define DIC_OFF_EVT 8'h20
`define DIC_OFF_EVT_MASK 8'h24
`define DIC_RST_WORD 16'h0000
`define DIC_RST_EVT 2'h0
`define DIC_VEC_NONE 5'h10
`define DIC_VEC_W 5
`define DIC_EXT_PINS 4
`endif

// >>> verilog/dic_pkg.sv
// Types shared by the interrupt controller
package dic_pkg;
  // Latched AHB address phase
  typedef struct packed
  {
    logic valid;
    logic write;
    logic [7:0] addr;
  } dic_aphase_s;
  // Per-unit access strobes decoded from the bus
  typedef struct packed
  {
    logic rd_sv;
    logic rd_vec;
    logic wr_vec;
    logic wr_stat;
    logic wr_pend;
    logic wr_mask;
  } dic_acc_s;
endpackage

// >>> verilog/dic_top.sv
// Dual interrupt controller with AHB-Lite register access
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dic_params.svh"

module dic_top
  import dic_pkg::*;
#(
  parameter int NREQ = 16
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic standalone_mode,
  input wire logic [2*NREQ-`DIC_EXT_PINS-1:0] fu_req_n,
  input wire logic [`DIC_EXT_PINS-1:0] ext_request_pins,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq_out_n_unit0,
  output logic irq_out_n_unit1,
  output logic irq_out
);

  // Vector encoding needs the request count to fit below the none code
  if (NREQ < `DIC_EXT_PINS || NREQ > 16)
  begin : g_bad_nreq
    $error("NREQ must lie between 4 and 16");
  end

  localparam int NALL = 2 * NREQ;

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [`DIC_EXT_PINS-1:0] ext_s1_r;
  logic [`DIC_EXT_PINS-1:0] ext_s2_r;
  logic [`DIC_EXT_PINS-1:0] ext_s3_r;
  logic [`DIC_EXT_PINS-1:0] ext_lvl_r;
  logic [NALL-1:0] req_lvl;
  logic [NALL-1:0] prev_r;
  logic [NALL-1:0] fall;
  logic [NREQ-1:0] pend_r [2];
  logic [NREQ-1:0] mask_r [2];
  logic [NREQ-1:0] stat_r [2];
  logic [NREQ-1:0] pend_nxt [2];
  logic [NREQ-1:0] stat_nxt [2];
  logic [1:0] frozen_r;
  logic [1:0] frozen_nxt;
  logic [1:0] lost;
  logic [1:0] irq_n_r;
  logic [1:0] irq_n_nxt;
  logic [1:0] evt_r;
  logic [1:0] evt_mask_r;
  logic [`DIC_VEC_W-1:0] vec [2];
  dic_acc_s acc [2];
  dic_aphase_s ap_r;
  logic accept;
  logic wr_now;
  logic [31:0] rd_val;
  logic [31:0] hrdata_r;

  // Highest request index wins; no active bit gives the none code
  function automatic logic [`DIC_VEC_W-1:0] prio_vec
    (input logic [NREQ-1:0] s);
    logic [`DIC_VEC_W-1:0] v;
    v = `DIC_VEC_NONE;
    for (int i = 0; i < NREQ; i++)
      if (s[i])
        v = `DIC_VEC_W'(i);
    return v;
  endfunction

  // One-hot of a vector; the none code selects nothing
  function automatic logic [NREQ-1:0] vec_bit
    (input logic [`DIC_VEC_W-1:0] v);
    logic [NREQ-1:0] b;
    b = '0;
    for (int i = 0; i < NREQ; i++)
      if (v == `DIC_VEC_W'(i))
        b[i] = 1'b1;
    return b;
  endfunction

  // Byte address of a unit register
  function automatic logic [7:0] reg_addr
    (input int u, input logic [7:0] off);
    return (u == 0) ? off : 8'(off + `DIC_UNIT_STRIDE);
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_s1_r <= '1;
      ext_s2_r <= '1;
      ext_s3_r <= '1;
      ext_lvl_r <= '1;
    end
    else if (clk_en)
    begin
      ext_s1_r <= ext_request_pins;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      if (ext_s2_r == ext_s3_r)
        ext_lvl_r <= ext_s3_r;
    end
  end

  // pins fill the top of unit 1
  assign req_lvl = {ext_lvl_r, fu_req_n};

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      prev_r <= '1;
    else if (clk_en)
      prev_r <= req_lvl;
  end
  assign fall = prev_r & ~req_lvl;

  // Bus accepts a transfer only while the clock enable is high
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign accept = hsel & htrans[1] & hready & clk_en;
  assign wr_now = ap_r.valid & ap_r.write & clk_en;

  // Address phase latch
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ap_r <= '0;
    else if (hready & clk_en)
    begin
      ap_r.valid <= hsel & htrans[1];
      ap_r.write <= hwrite;
      ap_r.addr <= {haddr[7:2], 2'b00};
    end
  end

  // Per-unit access strobes; reads act at the address phase
  always_comb
  begin
    for (int u = 0; u < 2; u++)
    begin
      acc[u].rd_sv = accept & !hwrite &
        (haddr[7:0] == reg_addr(u, `DIC_OFF_STAT) |
         haddr[7:0] == reg_addr(u, `DIC_OFF_VECT));
      acc[u].rd_vec = accept & !hwrite &
        (haddr[7:0] == reg_addr(u, `DIC_OFF_VECT));
      acc[u].wr_vec = wr_now &
        (ap_r.addr == reg_addr(u, `DIC_OFF_VECT));
      acc[u].wr_stat = wr_now &
        (ap_r.addr == reg_addr(u, `DIC_OFF_STAT));
      acc[u].wr_pend = wr_now &
        (ap_r.addr == reg_addr(u, `DIC_OFF_PEND));
      acc[u].wr_mask = wr_now &
        (ap_r.addr == reg_addr(u, `DIC_OFF_MASK));
    end
  end

  // vector always follows the status bits
  always_comb
  begin
    for (int u = 0; u < 2; u++)
      vec[u] = prio_vec(stat_r[u]);
  end

  // Next state of both units; each uses only its own flags
  always_comb
  begin
    logic [NREQ-1:0] p;
    logic [NREQ-1:0] clr;
    p = '0;
    clr = '0;
    for (int u = 0; u < 2; u++)
    begin
      // software set joins the captured edges
      p = pend_r[u] | fall[u*NREQ +: NREQ] |
        (acc[u].wr_pend ? hwdata[NREQ-1:0] : '0);
      // vector read clears the bit it points to
      // status write clears the chosen bits
      clr = (acc[u].wr_stat ? hwdata[NREQ-1:0] : '0) |
        (acc[u].rd_vec ? vec_bit(vec[u]) : '0);
      // a repeat edge on a held bit is swallowed
      lost[u] = frozen_r[u] & |(fall[u*NREQ +: NREQ] & pend_r[u]);
      if (frozen_r[u])
      begin
        // held requests wait, captured ones stay put
        pend_nxt[u] = p;
        stat_nxt[u] = stat_r[u] & ~clr;
      end
      else
      begin
        // unmasked bits move; masked ones drop
        // mask gates the path into status
        pend_nxt[u] = '0;
        stat_nxt[u] = (stat_r[u] & ~clr) | (p & mask_r[u]);
      end
      // vector write releases; status write keeps state
      if (acc[u].rd_sv)
        frozen_nxt[u] = 1'b1;
      else if (acc[u].wr_vec)
        frozen_nxt[u] = 1'b0;
      else
        frozen_nxt[u] = frozen_r[u];
      // output low while any status bit stands released
      irq_n_nxt[u] = !(|stat_nxt[u] & !frozen_nxt[u]);
      if (standalone_mode)
      begin
        pend_nxt[u] = '0;
        stat_nxt[u] = '0;
        frozen_nxt[u] = 1'b0;
        irq_n_nxt[u] = 1'b1;
        lost[u] = 1'b0;
      end
    end
  end

  // two unit register sets, updated together but apart
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int u = 0; u < 2; u++)
      begin
        pend_r[u] <= NREQ'(`DIC_RST_WORD);
        stat_r[u] <= NREQ'(`DIC_RST_WORD);
        mask_r[u] <= NREQ'(`DIC_RST_WORD);
      end
      frozen_r <= 2'h0;
      irq_n_r <= 2'h3;
    end
    else if (clk_en)
    begin
      for (int u = 0; u < 2; u++)
      begin
        pend_r[u] <= pend_nxt[u];
        stat_r[u] <= stat_nxt[u];
        if (acc[u].wr_mask)
          mask_r[u] <= hwdata[NREQ-1:0];
      end
      // each frozen flag from its own unit only
      frozen_r <= frozen_nxt;
      irq_n_r <= irq_n_nxt;
    end
  end

  assign irq_out_n_unit0 = irq_n_r[0];
  assign irq_out_n_unit1 = irq_n_r[1];

  // Lost-request events; a new event beats a same-cycle clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_r <= `DIC_RST_EVT;
      evt_mask_r <= `DIC_RST_EVT;
    end
    else if (clk_en)
    begin
      if (wr_now && ap_r.addr == `DIC_OFF_EVT)
        evt_r <= (evt_r & ~hwdata[1:0]) | lost;
      else
        evt_r <= evt_r | lost;
      if (wr_now && ap_r.addr == `DIC_OFF_EVT_MASK)
        evt_mask_r <= hwdata[1:0];
    end
  end
  assign irq_out = |(evt_r & evt_mask_r);

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    for (int u = 0; u < 2; u++)
    begin
      if (haddr[7:0] == reg_addr(u, `DIC_OFF_MASK))
        rd_val[NREQ-1:0] = mask_r[u];
      if (haddr[7:0] == reg_addr(u, `DIC_OFF_PEND))
        rd_val[NREQ-1:0] = pend_r[u];
      if (haddr[7:0] == reg_addr(u, `DIC_OFF_STAT))
        rd_val[NREQ-1:0] = stat_r[u];
      // none code sits above every valid index
      if (haddr[7:0] == reg_addr(u, `DIC_OFF_VECT))
        rd_val[`DIC_VEC_W-1:0] = vec[u];
    end
    if (haddr[7:0] == `DIC_OFF_EVT)
      rd_val[1:0] = evt_r;
    if (haddr[7:0] == `DIC_OFF_EVT_MASK)
      rd_val[1:0] = evt_mask_r;
  end

  // Read data captured at the address phase, so no wait state
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_r <= 32'h0000_0000;
    else if (accept & !hwrite)
      hrdata_r <= rd_val;
  end
  assign hrdata = hrdata_r;

  // Checks on the unit behaviour
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  int_low_a: assert property (
    (|stat_r[0] && !frozen_r[0] && !standalone_mode)
    |-> !irq_out_n_unit0)
    else $error("unit0 output not low with active status");

  read_freeze_a: assert property (
    (acc[1].rd_sv && !standalone_mode)
    |=> (frozen_r[1] && irq_out_n_unit1))
    else $error("status read did not freeze unit1");

  vec_release_a: assert property (
    (acc[0].wr_vec && !acc[0].rd_sv && !standalone_mode)
    |=> !frozen_r[0])
    else $error("vector write did not release unit0");

  stat_keep_a: assert property (
    (acc[0].wr_stat && !acc[0].rd_sv && !standalone_mode)
    |=> frozen_r[0] == $past(frozen_r[0]))
    else $error("status write changed frozen state");

  unit_apart_a: assert property (
    (clk_en && acc[0].rd_sv && !acc[1].rd_sv &&
     !acc[1].wr_vec && !standalone_mode)
    |=> $stable(frozen_r[1]))
    else $error("unit0 read touched unit1 state");

  release_drain_a: assert property (
    (clk_en && !frozen_r[0]) |=> pend_r[0] == '0)
    else $error("released unit kept pending bits");

  frozen_hold_a: assert property (
    (clk_en && frozen_r[1] && !standalone_mode)
    |=> (pend_r[1] & $past(pend_r[1])) == $past(pend_r[1]))
    else $error("frozen unit dropped a pending bit");

  edge_capture_a: assert property (
    (clk_en && frozen_r[0] && fall[5] && !standalone_mode)
    |=> pend_r[0][5])
    else $error("falling edge not captured");

  masked_drop_a: assert property (
    (clk_en && !frozen_r[0] && !mask_r[0][9] && !stat_r[0][9])
    |=> !stat_r[0][9])
    else $error("masked request reached status");

  standalone_a: assert property (
    standalone_mode[*2] |-> (irq_out_n_unit0 && irq_out_n_unit1))
    else $error("output active in stand-alone mode");

  none_code_a: assert property (
    (stat_r[0] == '0) |-> vec[0] == `DIC_VEC_NONE)
    else $error("empty status gave a valid vector");
endmodule
